// file: hdl/sws_pkg.sv
// constants, register map and state codes of the sleep/wake supervisor
// assumes a 100 MHz clock and a word-aligned byte-addressed register port
package sws_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int N_SUPPLY = 3;
  localparam int SUP_MAIN = 0;
  localparam int SUP_IO = 1;
  localparam int SUP_BUCK2 = 2;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_WD_CFG = 8'h08;
  localparam logic [7:0] OFF_WD_KICK = 8'h0c;
  localparam logic [7:0] OFF_RTC_LO = 8'h10;
  localparam logic [7:0] OFF_RTC_HI = 8'h14;
  localparam logic [7:0] OFF_CMP_LO = 8'h18;
  localparam logic [7:0] OFF_CMP_HI = 8'h1c;
  localparam logic [7:0] OFF_SLOW_INC = 8'h20;
  localparam logic [7:0] OFF_SLEEP_CFG = 8'h24;
  localparam logic [7:0] OFF_MEM_BASE = 8'h80;

  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_USB_EN_BIT = 1;
  localparam int CTRL_WAKE_POL_BIT = 2;
  localparam int CTRL_CMP_EN_BIT = 3;
  localparam int CTRL_SLOW_SEL_BIT = 4;
  localparam int STAT_WD_FLAG_BIT = 8;
  localparam int STAT_PEND_BIT = 9;
  localparam int WD_EN_BIT = 16;

  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] WD_PERIOD_RST = 16'hffff;
  localparam logic [31:0] SLOW_INC_RST = 32'h0000_0c80;
  localparam logic [7:0] SLEEP_CFG_RST = 8'h00;

  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_W = 17;
  localparam int STEP_NS = 100;
  localparam int STEP_CYCLES = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_NS = 1000;
  localparam int HOLD_CYCLES = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  localparam int MEM_WORDS = 32;
  localparam int MEM_AW = 5;

  typedef enum logic [3:0] {
    ST_AWAKE  = 4'b0001,
    ST_ENTER  = 4'b0010,
    ST_ASLEEP = 4'b0100,
    ST_EXIT   = 4'b1000
  } sws_state_t;
endpackage

// file: hdl/sws_mem_if.sv
// carrier between the supervisor and its retention memory
// assumes both ends share one clock
`timescale 1ns/1ps
interface sws_mem_if;
  logic rd;
  logic rdAny;
  logic wr;
  logic [sws_pkg::MEM_AW-1:0] addr;
  logic [sws_pkg::DATA_W-1:0] wdata;
  logic [sws_pkg::DATA_W-1:0] regData;
  logic [sws_pkg::DATA_W-1:0] rdata;
  modport ctrl(output rd, rdAny, wr, addr, wdata, regData, input rdata);
  modport mem(input rd, rdAny, wr, addr, wdata, regData, output rdata);
endinterface

// file: hdl/sws_retention_mem.sv
// 128-byte always-on memory and the register port read data flop
// assumes power loss is the only event that clears its contents
`timescale 1ns/1ps
module sws_retention_mem (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clkEn,
  sws_mem_if.mem bus
);
  logic [sws_pkg::DATA_W-1:0] store [sws_pkg::MEM_WORDS];
  logic [sws_pkg::DATA_W-1:0] rdata_q;

  // no reset: contents outlive every reset but loss of power
  always_ff @(posedge clk) begin
    if (clkEn && bus.wr) begin
      store[bus.addr] <= bus.wdata; // see R19
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (clkEn) begin
      if (bus.rd) begin
        rdata_q <= store[bus.addr];
      end else if (bus.rdAny) begin
        rdata_q <= bus.regData;
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  assign bus.rdata = rdata_q;
endmodule

// file: hdl/sws_supervisor.sv
// supervisor: reset hold, watchdog, power-mode controller, real-time counter
// assumes supply-good, usb and slow-tick inputs are synchronous to clk
//
// Contract
// R1: hold chip reset from power-up until every supply reports good.
// R2: any supply lost re-enters reset; restart as from cold power-up.
// R3: watchdog is 16 bits, counts milliseconds, own prescaler.
// R4: watchdog period programmable from 1 ms to 65535 ms.
// R5: watchdog not kicked within period issues a full chip reset.
// R6: software can read whether last reset came from the watchdog.
// R7: watchdog counts and fires only in the awake state.
// R8: sleep starts on control-register write or usb standby request.
// R9: software and usb request sleep only while awake.
// R10: awake and asleep are joined by intermediate transition states.
// R11: wake accepted only asleep; stimuli during entry held until asleep.
// R12: wake pin edge, polarity chosen by software.
// R13: wake when 64-bit counter reaches programmed compare value.
// R14: wake on usb resume only when usb is enabled.
// R15: awake, counter adds one per main oscillator tick.
// R16: asleep, counter may move to 31,250 Hz tick by configuration.
// R17: on slow tick the counter adds a programmable increment.
// R18: supply lost during either transition issues system reset.
// R19: 128-byte memory keeps software state through deep sleep.
// R20: software should set sleep config to minimum power settings.
// R21: watchdog flag survives its own reset, cleared by supply loss.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module sws_supervisor #(
  parameter int MS_CYCLES = sws_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [sws_pkg::N_SUPPLY-1:0] supplyGood,
  input wire logic usbStandbyReq,
  input wire logic usbResume,
  input wire logic wakePin,
  input wire logic slowTick,
  input wire logic [sws_pkg::ADDR_W-1:0] regAddr,
  input wire logic [sws_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [sws_pkg::DATA_W-1:0] regRdata,
  output logic chipResetN,
  output logic [3:0] powerState,
  output logic [7:0] sleepCfgOut
);
  function automatic logic isMem(input logic [7:0] a);
    return a[7] == 1'b1;
  endfunction

  sws_mem_if memBus();

  sws_pkg::sws_state_t state_q;
  logic [sws_pkg::CNT_W-1:0] step_q;
  logic [3:0] ctrl_q;
  logic wdEn_q;
  logic [15:0] wdPeriod_q;
  logic [15:0] wdCount_q;
  logic [sws_pkg::MS_W-1:0] msCnt_q;
  logic [sws_pkg::CNT_W-1:0] hold_q;
  logic wdFlag_q;
  logic [63:0] rtc_q;
  logic [63:0] cmp_q;
  logic [31:0] slowInc_q;
  logic [7:0] sleepCfg_q;
  logic wakePend_q;
  logic pinPrev_q;
  logic chipResetN_q;
  logic [7:0] sleepCfgOut_q;
  logic [sws_pkg::DATA_W-1:0] regData;

  logic allGood;
  logic sysClr;
  logic wrHit;
  logic wdRun;
  logic msTick;
  logic wdExpire;
  logic sleepReq;
  logic pinEdge;
  logic rtcHit;
  logic usbWake;
  logic wakeStim;

  assign allGood = &supplyGood;
  assign wrHit = regWr && !isMem(regAddr);
  assign wdRun = allGood && wdEn_q && hold_q == 8'h00 &&
                 state_q == sws_pkg::ST_AWAKE; // see R7
  assign msTick = wdRun &&
                  msCnt_q == sws_pkg::MS_W'(MS_CYCLES - 1); // see R3
  assign wdExpire = msTick &&
                    (17'(wdCount_q) + 17'h00001) >= 17'(wdPeriod_q); // see R5
  assign sysClr = !allGood || wdExpire; // see R2
  assign sleepReq = (wrHit && regAddr == sws_pkg::OFF_CTRL &&
                     regWdata[sws_pkg::CTRL_SLEEP_BIT]) ||
                    usbStandbyReq; // see R8
  assign pinEdge = ctrl_q[sws_pkg::CTRL_WAKE_POL_BIT - 1] ?
                   (wakePin && !pinPrev_q) :
                   (!wakePin && pinPrev_q); // see R12
  assign rtcHit = ctrl_q[sws_pkg::CTRL_CMP_EN_BIT - 1] &&
                  rtc_q >= cmp_q; // see R13
  assign usbWake = ctrl_q[sws_pkg::CTRL_USB_EN_BIT - 1] &&
                   usbResume; // see R14
  assign wakeStim = pinEdge || rtcHit || usbWake;

  // chip reset output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chipResetN_q <= 1'b0;
    end else if (clkEn) begin
      chipResetN_q <= allGood && !wdExpire && hold_q == 8'h00; // see R1
    end
  end

  // watchdog reset stretch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_q <= 8'h00;
    end else if (clkEn) begin
      if (!allGood) begin
        hold_q <= 8'h00;
      end else if (wdExpire) begin
        hold_q <= sws_pkg::CNT_W'(sws_pkg::HOLD_CYCLES - 1); // see R5
      end else if (hold_q != 8'h00) begin
        hold_q <= hold_q - 8'h01;
      end
    end
  end

  // watchdog-cause flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdFlag_q <= 1'b0;
    end else if (clkEn) begin
      if (!allGood) begin
        wdFlag_q <= 1'b0; // see R21
      end else if (wdExpire) begin
        wdFlag_q <= 1'b1; // see R6
      end
    end
  end

  // millisecond prescaler and watchdog counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      msCnt_q <= 17'h00000;
      wdCount_q <= 16'h0000;
    end else if (clkEn) begin
      if (sysClr || (wrHit && regAddr == sws_pkg::OFF_WD_KICK)) begin
        msCnt_q <= 17'h00000;
        wdCount_q <= 16'h0000;
      end else if (msTick) begin
        msCnt_q <= 17'h00000;
        wdCount_q <= wdCount_q + 16'h0001; // see R3
      end else if (wdRun) begin
        msCnt_q <= msCnt_q + 17'h00001;
      end
    end
  end

  // software control registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= sws_pkg::CTRL_RST;
      wdEn_q <= 1'b0;
      wdPeriod_q <= sws_pkg::WD_PERIOD_RST;
      cmp_q <= 64'h0000_0000_0000_0000;
      slowInc_q <= sws_pkg::SLOW_INC_RST;
      sleepCfg_q <= sws_pkg::SLEEP_CFG_RST;
    end else if (clkEn) begin
      if (sysClr) begin
        ctrl_q <= sws_pkg::CTRL_RST;
        wdEn_q <= 1'b0;
        wdPeriod_q <= sws_pkg::WD_PERIOD_RST;
        cmp_q <= 64'h0000_0000_0000_0000;
        slowInc_q <= sws_pkg::SLOW_INC_RST;
        sleepCfg_q <= sws_pkg::SLEEP_CFG_RST;
      end else if (wrHit) begin
        unique case (regAddr)
          sws_pkg::OFF_CTRL: ctrl_q <= regWdata[4:1];
          sws_pkg::OFF_WD_CFG: begin
            wdEn_q <= regWdata[sws_pkg::WD_EN_BIT];
            // zero would mean no time at all; clamp to 1 ms
            wdPeriod_q <= (regWdata[15:0] == 16'h0000) ? 16'h0001 :
                          regWdata[15:0]; // see R4
          end
          sws_pkg::OFF_CMP_LO: cmp_q[31:0] <= regWdata;
          sws_pkg::OFF_CMP_HI: cmp_q[63:32] <= regWdata;
          sws_pkg::OFF_SLOW_INC: slowInc_q <= regWdata;
          sws_pkg::OFF_SLEEP_CFG: sleepCfg_q <= regWdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // power-mode controller
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= sws_pkg::ST_AWAKE;
      step_q <= 8'h00;
    end else if (clkEn) begin
      if (sysClr) begin
        state_q <= sws_pkg::ST_AWAKE; // see R18
        step_q <= 8'h00;
      end else begin
        unique case (state_q)
          sws_pkg::ST_AWAKE: begin
            if (sleepReq) begin
              state_q <= sws_pkg::ST_ENTER; // see R9
              step_q <= 8'h00;
            end
          end
          sws_pkg::ST_ENTER: begin
            if (step_q == sws_pkg::CNT_W'(sws_pkg::STEP_CYCLES - 1)) begin
              state_q <= sws_pkg::ST_ASLEEP; // see R10
              step_q <= 8'h00;
            end else begin
              step_q <= step_q + 8'h01;
            end
          end
          sws_pkg::ST_ASLEEP: begin
            if (wakePend_q) begin
              state_q <= sws_pkg::ST_EXIT; // see R11
              step_q <= 8'h00;
            end
          end
          sws_pkg::ST_EXIT: begin
            if (step_q == sws_pkg::CNT_W'(sws_pkg::STEP_CYCLES - 1)) begin
              state_q <= sws_pkg::ST_AWAKE; // see R10
              step_q <= 8'h00;
            end else begin
              step_q <= step_q + 8'h01;
            end
          end
          default: begin
            state_q <= sws_pkg::ST_AWAKE;
            step_q <= 8'h00;
          end
        endcase
      end
    end
  end

  // wake stimulus hold
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wakePend_q <= 1'b0;
      pinPrev_q <= 1'b0;
    end else if (clkEn) begin
      pinPrev_q <= wakePin;
      if (sysClr || state_q == sws_pkg::ST_EXIT) begin
        wakePend_q <= 1'b0;
      end else if (wakeStim && (state_q == sws_pkg::ST_ENTER ||
                                state_q == sws_pkg::ST_ASLEEP)) begin
        wakePend_q <= 1'b1; // see R11
      end
    end
  end

  // real-time counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rtc_q <= 64'h0000_0000_0000_0000;
    end else if (clkEn) begin
      if (!allGood) begin
        rtc_q <= 64'h0000_0000_0000_0000;
      end else if (state_q == sws_pkg::ST_ASLEEP &&
                   ctrl_q[sws_pkg::CTRL_SLOW_SEL_BIT - 1]) begin
        if (slowTick) begin // see R16
          rtc_q <= rtc_q + {32'h0000_0000, slowInc_q}; // see R17
        end
      end else begin
        rtc_q <= rtc_q + 64'h0000_0000_0000_0001; // see R15
      end
    end
  end

  // sleep configuration applied while asleep
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sleepCfgOut_q <= 8'h00;
    end else if (clkEn) begin
      sleepCfgOut_q <= (state_q == sws_pkg::ST_ASLEEP) ? sleepCfg_q : 8'h00;
    end
  end

  // register read mux
  always_comb begin
    regData = 32'h0000_0000;
    unique case (regAddr)
      sws_pkg::OFF_CTRL: regData = {27'h0000000, ctrl_q, 1'b0};
      sws_pkg::OFF_STATUS: regData = {22'h000000, wakePend_q, wdFlag_q,
                                      4'h0, state_q};
      sws_pkg::OFF_WD_CFG: regData = {15'h0000, wdEn_q, wdPeriod_q};
      sws_pkg::OFF_WD_KICK: regData = {16'h0000, wdCount_q};
      sws_pkg::OFF_RTC_LO: regData = rtc_q[31:0];
      sws_pkg::OFF_RTC_HI: regData = rtc_q[63:32];
      sws_pkg::OFF_CMP_LO: regData = cmp_q[31:0];
      sws_pkg::OFF_CMP_HI: regData = cmp_q[63:32];
      sws_pkg::OFF_SLOW_INC: regData = slowInc_q;
      sws_pkg::OFF_SLEEP_CFG: regData = {24'h000000, sleepCfg_q};
      default: regData = 32'h0000_0000;
    endcase
  end

  assign memBus.rd = regRd && isMem(regAddr);
  assign memBus.rdAny = regRd;
  assign memBus.wr = regWr && isMem(regAddr); // see R19
  assign memBus.addr = regAddr[6:2];
  assign memBus.wdata = regWdata;
  assign memBus.regData = regData;

  sws_retention_mem retention (
    .clk(clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .bus(memBus)
  );

  assign regRdata = memBus.rdata;
  assign chipResetN = chipResetN_q;
  assign powerState = state_q;
  assign sleepCfgOut = sleepCfgOut_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_por;
    clkEn && !allGood |=> !chipResetN_q;
  endproperty
  a_por: assert property (p_por) else $error("reset not held"); // see R1

  property p_brownout;
    clkEn && !allGood |=> state_q == sws_pkg::ST_AWAKE &&
      rtc_q == 64'h0000_0000_0000_0000 && !wdFlag_q;
  endproperty
  a_brownout: assert property (p_brownout)
    else $error("no cold restart"); // see R2

  property p_wd_step;
    clkEn && msTick && !wdExpire |=>
      wdCount_q == (($past(wrHit) &&
                     $past(regAddr) == sws_pkg::OFF_WD_KICK) ? 16'h0000 :
                    $past(wdCount_q) + 16'h0001);
  endproperty
  a_wd_step: assert property (p_wd_step)
    else $error("watchdog step wrong"); // see R3

  property p_wd_fire;
    clkEn && wdExpire |=> !chipResetN_q && wdFlag_q && hold_q != 8'h00;
  endproperty
  a_wd_fire: assert property (p_wd_fire)
    else $error("watchdog did not reset"); // see R5

  property p_wd_idle;
    clkEn && state_q != sws_pkg::ST_AWAKE |-> !msTick && !wdExpire;
  endproperty
  a_wd_idle: assert property (p_wd_idle)
    else $error("watchdog ran out of awake"); // see R7

  property p_sleep_req;
    clkEn && allGood && !wdExpire && state_q == sws_pkg::ST_AWAKE &&
      sleepReq |=> state_q == sws_pkg::ST_ENTER;
  endproperty
  a_sleep_req: assert property (p_sleep_req)
    else $error("sleep not started"); // see R8

  property p_via_enter;
    $rose(state_q == sws_pkg::ST_ASLEEP) |->
      $past(state_q) == sws_pkg::ST_ENTER;
  endproperty
  a_via_enter: assert property (p_via_enter)
    else $error("asleep not via entry"); // see R10

  property p_no_wake_awake;
    state_q == sws_pkg::ST_AWAKE |-> !wakePend_q;
  endproperty
  a_no_wake_awake: assert property (p_no_wake_awake)
    else $error("wake pending while awake"); // see R11

  property p_rtc_fast;
    clkEn && allGood && state_q == sws_pkg::ST_AWAKE |=>
      rtc_q == $past(rtc_q) + 64'h0000_0000_0000_0001;
  endproperty
  a_rtc_fast: assert property (p_rtc_fast)
    else $error("counter not ticking"); // see R15

  property p_rtc_slow;
    clkEn && allGood && state_q == sws_pkg::ST_ASLEEP &&
      ctrl_q[sws_pkg::CTRL_SLOW_SEL_BIT - 1] && slowTick |=>
      rtc_q == $past(rtc_q) + {32'h0000_0000, $past(slowInc_q)};
  endproperty
  a_rtc_slow: assert property (p_rtc_slow)
    else $error("slow increment wrong"); // see R17

  property p_flag_kept;
    hold_q != 8'h00 |-> wdFlag_q;
  endproperty
  a_flag_kept: assert property (p_flag_kept)
    else $error("flag lost in watchdog reset"); // see R21

  property p_cv_sleep;
    state_q == sws_pkg::ST_ASLEEP ##1 state_q == sws_pkg::ST_EXIT;
  endproperty
  c_cv_sleep: cover property (p_cv_sleep);

  property p_cv_wd;
    wdExpire;
  endproperty
  c_cv_wd: cover property (p_cv_wd);

  property p_cv_early_wake;
    state_q == sws_pkg::ST_ENTER && wakeStim;
  endproperty
  c_cv_early_wake: cover property (p_cv_early_wake);
endmodule

// file: dv/sws_supply_partner.sv
// model of the supply monitors, usb standby logic and slow oscillator
// assumes its tasks are called from one bench process on clk
`timescale 1ns/1ps
module sws_supply_partner #(
  parameter int SLOW_DIV = 40
) (
  input wire logic clk,
  input wire logic [3:0] powerState,
  output logic [sws_pkg::N_SUPPLY-1:0] supplyGood,
  output logic usbStandbyReq,
  output logic usbResume,
  output logic wakePin,
  output logic slowTick
);
  int divCnt = 0;
  initial begin
    supplyGood = '0;
    usbStandbyReq = 1'h0;
    usbResume = 1'h0;
    wakePin = 1'h0;
    slowTick = 1'h0;
  end
  // free-running slow oscillator tick
  always @(posedge clk) begin
    divCnt <= (divCnt == SLOW_DIV - 1) ? 0 : divCnt + 1;
    slowTick <= (divCnt == SLOW_DIV - 1);
  end
  task automatic setSupply(input logic [sws_pkg::N_SUPPLY-1:0] m);
    @(posedge clk);
    supplyGood <= m;
  endtask
  // standby request only from the awake state
  task automatic standby();
    @(posedge clk);
    if (powerState === sws_pkg::ST_AWAKE) begin
      usbStandbyReq <= 1'h1;
      @(posedge clk);
      usbStandbyReq <= 1'h0;
    end
  endtask
  task automatic resume();
    @(posedge clk);
    usbResume <= 1'h1;
    @(posedge clk);
    usbResume <= 1'h0;
  endtask
  task automatic pin(input logic v);
    @(posedge clk);
    wakePin <= v;
  endtask
endmodule

// file: dv/sleep_wake_supervisor_tb.sv
// self-checking bench of the supervisor with its partner model
// assumes the bench is the top and MS_CYCLES shrinks the ms tick
`timescale 1ns/1ps
module sleep_wake_supervisor_tb;
  localparam int MSC = 20;
  localparam logic [3:0] AWK = sws_pkg::ST_AWAKE;
  localparam logic [3:0] ENT = sws_pkg::ST_ENTER;
  localparam logic [3:0] SLP = sws_pkg::ST_ASLEEP;
  localparam logic [3:0] EXT = sws_pkg::ST_EXIT;
  logic clk, rstn, clkEn, regWr, regRd, chipResetN;
  logic usbStandbyReq, usbResume, wakePin, slowTick;
  logic [2:0] supplyGood;
  logic [7:0] regAddr, sleepCfgOut;
  logic [31:0] regWdata, regRdata, d0, d1;
  logic [3:0] powerState;
  int failures = 0;
  int n_checks = 0;
  int n;

  sws_supervisor #(.MS_CYCLES(MSC)) u_sws_supervisor (
    .clk(clk), .rstn(rstn), .clkEn(clkEn), .supplyGood(supplyGood),
    .usbStandbyReq(usbStandbyReq), .usbResume(usbResume),
    .wakePin(wakePin), .slowTick(slowTick), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .chipResetN(chipResetN),
    .powerState(powerState), .sleepCfgOut(sleepCfgOut));
  sws_supply_partner u_sws_supply_partner (
    .clk(clk), .powerState(powerState), .supplyGood(supplyGood),
    .usbStandbyReq(usbStandbyReq), .usbResume(usbResume),
    .wakePin(wakePin), .slowTick(slowTick));

  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chkW(input string what, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chkS(input string what, input logic [3:0] e, g);
    chkW(what, {28'h0, e}, {28'h0, g});
  endtask
  task automatic chkB(input string what, input logic e, g);
    chkW(what, {31'h0, e}, {31'h0, g});
  endtask
  // sel 0 waits for a state, 1 for a reset level, 2 for a slow tick
  task automatic waitOn(input int sel, input logic [3:0] v, input int lim,
                        output int k);
    k = 0;
    for (int i = 1; i <= lim; i++) begin
      @(posedge clk);
      #1;
      if ((sel == 0 && powerState === v) || (sel == 1 &&
          chipResetN === v[0]) || (sel == 2 && slowTick === 1'h1)) begin
        k = i;
        break;
      end
    end
    if (k == 0) begin
      failures++;
      $display("ERROR wait %0d expected %h seen timeout", sel, v);
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'h0;
    #1 d = regRdata;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chkW($sformatf("reg %h", a), e, d);
  endtask

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  initial begin
    rstn = 1'h0;
    clkEn = 1'h1;
    regAddr = '0;
    regWdata = '0;
    regWr = 1'h0;
    regRd = 1'h0;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    repeat (4) @(posedge clk);
    #1 chkB("reset without supplies", 1'h0, chipResetN);
    u_sws_supply_partner.setSupply(3'h7);
    waitOn(1, 4'h1, 4, n);
    chkS("state after reset", AWK, powerState);
    rdChk(sws_pkg::OFF_CTRL, 32'h0);
    @(posedge clk);
    #1 chkW("rdata idle", 32'h0, regRdata);
    rdChk(sws_pkg::OFF_WD_CFG, 32'h0000_ffff);
    rdChk(sws_pkg::OFF_SLOW_INC, 32'h0000_0c80);
    rdChk(sws_pkg::OFF_SLEEP_CFG, 32'h0);
    rdChk(8'h40, 32'h0);
    wr(sws_pkg::OFF_MEM_BASE, 32'hcafe_0001);
    wr(8'hfc, 32'h5a5a_a5a5);
    @(posedge clk);
    regRd <= 1'h1;
    regAddr <= sws_pkg::OFF_RTC_LO;
    @(posedge clk);
    #1 d0 = regRdata;
    @(posedge clk);
    regRd <= 1'h0;
    #1 d1 = regRdata;
    chkW("rtc step awake", d0 + 32'h1, d1);
    // clock enable low freezes the counter
    rd(sws_pkg::OFF_RTC_LO, d0);
    @(posedge clk);
    clkEn <= 1'h0;
    repeat (20) @(posedge clk);
    clkEn <= 1'h1;
    rd(sws_pkg::OFF_RTC_LO, d1);
    chkW("rtc frozen", d0 + 32'h3, d1);
    // pin edge during entry acted on once asleep
    wr(sws_pkg::OFF_SLEEP_CFG, 32'h0000_00a5);
    wr(sws_pkg::OFF_CTRL, 32'h5);
    #1 chkS("entering", ENT, powerState);
    u_sws_supply_partner.pin(1'h1);
    waitOn(0, SLP, 20, n);
    waitOn(0, EXT, 4, n);
    waitOn(0, AWK, 15, n);
    chkW("exit cycles", 32'd10, 32'(n));
    rdChk(sws_pkg::OFF_MEM_BASE, 32'hcafe_0001);
    u_sws_supply_partner.pin(1'h0);
    // usb standby, resume gated by usb enable
    u_sws_supply_partner.standby();
    waitOn(0, ENT, 3, n);
    waitOn(0, SLP, 15, n);
    // first entering cycle is already spent by the wait above
    chkW("enter cycles", 32'(sws_pkg::STEP_CYCLES - 1), 32'(n));
    @(posedge clk);
    #1 chkW("sleep cfg", 32'ha5, {24'h0, sleepCfgOut});
    u_sws_supply_partner.resume();
    repeat (20) @(posedge clk);
    #1 chkS("resume ignored", SLP, powerState);
    wr(sws_pkg::OFF_CTRL, 32'h6);
    u_sws_supply_partner.resume();
    waitOn(0, EXT, 4, n);
    waitOn(0, AWK, 15, n);
    chkW("cfg awake", 32'h0, {24'h0, sleepCfgOut});
    // falling-edge polarity
    wr(sws_pkg::OFF_CTRL, 32'h1);
    waitOn(0, SLP, 15, n);
    u_sws_supply_partner.pin(1'h1);
    repeat (10) @(posedge clk);
    #1 chkS("rise ignored", SLP, powerState);
    u_sws_supply_partner.pin(1'h0);
    waitOn(0, EXT, 4, n);
    waitOn(0, AWK, 15, n);
    // slow oscillator with increment, then compare wake
    wr(sws_pkg::OFF_SLOW_INC, 32'h5);
    wr(sws_pkg::OFF_CTRL, 32'h11);
    waitOn(0, SLP, 15, n);
    waitOn(2, 4'h0, 100, n);
    repeat (2) @(posedge clk);
    rd(sws_pkg::OFF_RTC_LO, d0);
    repeat (5) @(posedge clk);
    rd(sws_pkg::OFF_RTC_LO, d1);
    chkW("rtc between ticks", d0, d1);
    waitOn(2, 4'h0, 100, n);
    repeat (2) @(posedge clk);
    rd(sws_pkg::OFF_RTC_LO, d1);
    chkW("rtc slow step", d0 + 32'h5, d1);
    wr(sws_pkg::OFF_CMP_LO, d1 + 32'hf);
    wr(sws_pkg::OFF_CMP_HI, 32'h0);
    wr(sws_pkg::OFF_CTRL, 32'h18);
    waitOn(0, EXT, 200, n);
    waitOn(0, AWK, 15, n);
    wr(sws_pkg::OFF_CTRL, 32'h0);
    // watchdog: clamp, kick, expiry, hold, flag
    wr(sws_pkg::OFF_WD_CFG, 32'h0);
    rdChk(sws_pkg::OFF_WD_CFG, 32'h1);
    wr(sws_pkg::OFF_WD_CFG, 32'h0001_0003);
    for (int i = 0; i < 2; i++) begin
      repeat (40) @(posedge clk);
      wr(sws_pkg::OFF_WD_KICK, 32'h0);
    end
    repeat (50) @(posedge clk);
    #1 chkB("kicked watchdog", 1'h1, chipResetN);
    waitOn(1, 4'h0, 20, n);
    waitOn(1, 4'h1, 120, n);
    chkW("hold cycles", 32'(sws_pkg::HOLD_CYCLES), 32'(n));
    rdChk(sws_pkg::OFF_STATUS, 32'h0000_0101);
    rdChk(sws_pkg::OFF_WD_CFG, 32'h0000_ffff);
    rdChk(8'hfc, 32'h5a5a_a5a5);
    wr(sws_pkg::OFF_WD_CFG, 32'h0001_0001);
    wr(sws_pkg::OFF_CTRL, 32'h1);
    repeat (100) @(posedge clk);
    #1 chkB("watchdog asleep", 1'h1, chipResetN);
    u_sws_supply_partner.pin(1'h1);
    u_sws_supply_partner.pin(1'h0);
    waitOn(0, AWK, 20, n);
    wr(sws_pkg::OFF_WD_CFG, 32'h0);
    // supply lost during entry
    wr(sws_pkg::OFF_CTRL, 32'h1);
    u_sws_supply_partner.setSupply(3'h3);
    waitOn(1, 4'h0, 3, n);
    repeat (5) @(posedge clk);
    #1 chkB("held while low", 1'h0, chipResetN);
    u_sws_supply_partner.setSupply(3'h7);
    waitOn(1, 4'h1, 5, n);
    rdChk(sws_pkg::OFF_STATUS, 32'h1);
    rdChk(sws_pkg::OFF_CTRL, 32'h0);
    final_report();
  end
endmodule
